// file: common/pst_pkg.sv
/*
  pst_pkg: shared constants and carriers for the potentiometer volatile
  register bank (status and terminal control).
  Assumes: one 10 MHz clock; the serial front end decodes commands
  into one-cycle requests on the same clock.
*/
package pst_pkg;

  // ==========================================================
  // widths and address map
  localparam int unsigned PST_DW    = 9;
  localparam int unsigned PST_AW    = 4;
  localparam int unsigned PST_NNET  = 4;
  localparam logic [3:0] ADR_VWIP0  = 4'h0;
  localparam logic [3:0] ADR_VWIP1  = 4'h1;
  localparam logic [3:0] ADR_NVWIP0 = 4'h2;
  localparam logic [3:0] ADR_NVWIP1 = 4'h3;
  localparam logic [3:0] ADR_TCTL0  = 4'h4;
  localparam logic [3:0] ADR_STATUS = 4'h5;
  localparam logic [3:0] ADR_VWIP2  = 4'h6;
  localparam logic [3:0] ADR_VWIP3  = 4'h7;
  localparam logic [3:0] ADR_NVWIP2 = 4'h8;
  localparam logic [3:0] ADR_NVWIP3 = 4'h9;
  localparam logic [3:0] ADR_TCTL1  = 4'hA;

  // ==========================================================
  // status field positions
  localparam int unsigned ST_WP_BIT    = 0;
  localparam int unsigned ST_RSV1_BIT  = 1;
  localparam int unsigned ST_LOCK0_BIT = 2;
  localparam int unsigned ST_LOCK1_BIT = 3;
  localparam int unsigned ST_NVWA_BIT  = 4;
  localparam int unsigned ST_LOCK2_BIT = 5;
  localparam int unsigned ST_LOCK3_BIT = 6;
  localparam int unsigned ST_RSV7_BIT  = 7;
  localparam int unsigned ST_RSV8_BIT  = 8;

  // ==========================================================
  // terminal control layout: per network nibble {hw_n, a, w, b}
  localparam int unsigned TC_B_BIT   = 0;
  localparam int unsigned TC_W_BIT   = 1;
  localparam int unsigned TC_A_BIT   = 2;
  localparam int unsigned TC_HW_BIT  = 3;
  localparam int unsigned TC_RSV_BIT = 8;
  localparam logic [8:0]  TC_RESET   = 9'h1FF;
  localparam logic [8:0]  WIPER_RESET = 9'h080;

  // ==========================================================
  // command codes from the serial front end
  typedef enum logic [1:0] {
    PST_CMD_WRITE = 2'b00,
    PST_CMD_INCR  = 2'b01,
    PST_CMD_DECR  = 2'b10,
    PST_CMD_READ  = 2'b11
  } pst_cmd_e;

  typedef struct packed {
    logic     valid;
    pst_cmd_e cmd;
    logic [3:0] addr;
    logic [8:0] wdata;
  } pst_req_s;

  typedef struct packed {
    logic       valid;
    logic [8:0] rdata;
    logic       error;
    logic       done;
  } pst_rsp_s;

  // per network switch controls
  typedef struct packed {
    logic hw_shutdown_n;
    logic term_a_connect;
    logic wiper_connect;
    logic term_b_connect;
  } pst_term_s;

endpackage : pst_pkg

// file: verilog/pst_sync.sv
/*
  pst_sync: two-flop synchroniser for asynchronous pin levels.
  Assumes: destination clock is i_mclk; first flop feeds only the second.
*/
`timescale 1ns/1ps
module pst_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  input  wire logic [W-1:0] i_rst_val,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } pst_sync_s;

  pst_sync_s st_r;
  pst_sync_s st_nxt;

  // refuse a zero width while elaborating, not at run time
  if (W < 1) begin : g_bad_width
    $error("pst_sync: width must be at least one");
  end

  // ==========================================================
  // shift chain; reset clears both flops to zero, i_rst_val is never used
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = i_async;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.sync;
  logic unused_rv;
  assign unused_rv = |i_rst_val;
endmodule : pst_sync

// file: verilog/pst_tctl_reg.sv
/*
  pst_tctl_reg: one nine-bit terminal control register with per-network
  lock masking and deferred application to the terminal switches.
  Assumes: writes arrive as one-cycle strobes; i_apply pulses when the
  carrying serial command completes.
*/
`timescale 1ns/1ps
module pst_tctl_reg
  import pst_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_wr,
  input  wire logic [8:0] i_wdata,
  input  wire logic [1:0] i_lock,
  input  wire logic       i_apply,
  output logic      [8:0] o_value,
  output logic      [7:0] o_switch
);
  typedef struct packed {
    logic [7:0] shadow;
    logic [7:0] live;
  } pst_tc_s;

  pst_tc_s st_r;
  pst_tc_s st_nxt;

  // ==========================================================
  // locked nibbles keep old bits; the reserved top bit is never stored
  always_comb begin
    st_nxt = st_r;
    if (i_wr) begin
      if (!i_lock[0]) st_nxt.shadow[3:0] = i_wdata[3:0];
      if (!i_lock[1]) st_nxt.shadow[7:4] = i_wdata[7:4];
    end
    if (i_apply) begin
      st_nxt.live = st_nxt.shadow;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= {TC_RESET[7:0], TC_RESET[7:0]};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_value  = {1'b1, st_r.shadow};
  assign o_switch = st_r.live;
endmodule : pst_tctl_reg

// file: verilog/pst_regs.sv
/*
  pst_regs: volatile register bank of a quad digital potentiometer:
  four volatile wipers, status, two terminal control registers.
  Assumes: a serial front end on i_mclk issues one-cycle requests and
  a one-cycle command-complete strobe; nonvolatile lock and protect bits
  and the write-active level come from the memory controller.
*/
// Notes on behaviour
// - seven volatile locations: wipers, status, terminal controls
// - status at address 05h, read only
// - reserved bits always read as one
// - status bits 6,5,3,2 show network locks
// - locked network refuses wiper and terminal writes
// - lock bits mirror nonvolatile, reloaded at reset
// - lock and protect bits not writable normally
// - status bit 4 shows write cycle active
// - during write cycle only 00h,01h,04h,05h allowed
// - status bit 0 is pin OR internal protect
// - protection blocks every nonvolatile write
// - protection never blocks volatile register writes
// - terminal registers: four bits per network
// - terminal value applies after command completes
// - terminal registers reset to 1FFh
// - zero hardware bit forces network shutdown
// - terminal bits connect A, W, B when one
// - terminal changes leave wipers untouched
// - locations nine bits wide, sixteen addresses
// - disallowed command raises error condition
`timescale 1ns/1ps
module pst_regs
  import pst_pkg::*;
#(
  parameter int unsigned WIPER_FULL = 256
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst,
  input  wire pst_pkg::pst_req_s    i_req,
  input  wire logic                 i_cmd_done,
  input  wire logic                 i_err_clear,
  input  wire logic                 i_wp_pin_n,
  input  wire logic                 i_nv_wp,
  input  wire logic [3:0]           i_nv_lock,
  input  wire logic                 i_nv_write_active,
  output pst_pkg::pst_rsp_s         o_rsp,
  output logic                      o_nv_write_req,
  output logic [3:0]                o_nv_write_addr,
  output logic [8:0]                o_nv_write_data,
  output pst_pkg::pst_term_s [3:0]  o_term,
  output logic [3:0][8:0]           o_wiper
);
  import pst_pkg::*;

  // only the two ladder sizes have a defined full-scale clamp
  if (WIPER_FULL != 256 && WIPER_FULL != 128) begin : g_bad_full
    $error("pst_regs: WIPER_FULL must be 128 or 256");
  end

  localparam logic [8:0] WFULL = 9'(WIPER_FULL);

  // ==========================================================
  // module state
  typedef struct packed {
    logic [3:0][8:0] wiper;
    logic [3:0]      lock;
    logic            wp_int;
    logic            nvwa;
    logic            error;
    pst_rsp_s        rsp;
    logic            nvw_req;
    logic [3:0]      nvw_addr;
    logic [8:0]      nvw_data;
    pst_term_s [3:0] term;
  } pst_st_s;

  pst_st_s st_r;
  pst_st_s st_nxt;

  logic       wp_pin_n_s;
  logic [8:0] tc0_val, tc1_val;
  logic [7:0] tc0_sw, tc1_sw;
  logic       tc0_wr, tc1_wr;
  logic       allowed, is_write;

  // ==========================================================
  // helpers: network owning an address, and its wiper index
  function automatic logic [2:0] net_of(input logic [3:0] a);
    unique case (a)
      ADR_VWIP0, ADR_NVWIP0: net_of = 3'h0;
      ADR_VWIP1, ADR_NVWIP1: net_of = 3'h1;
      ADR_VWIP2, ADR_NVWIP2: net_of = 3'h2;
      ADR_VWIP3, ADR_NVWIP3: net_of = 3'h3;
      default:               net_of = 3'h4;
    endcase
  endfunction : net_of

  function automatic logic is_vwiper(input logic [3:0] a);
    is_vwiper = (a == ADR_VWIP0) || (a == ADR_VWIP1) ||
                (a == ADR_VWIP2) || (a == ADR_VWIP3);
  endfunction : is_vwiper

  function automatic logic is_nv(input logic [3:0] a);
    is_nv = (a == ADR_NVWIP0) || (a == ADR_NVWIP1) || (a == ADR_NVWIP2) ||
            (a == ADR_NVWIP3) || (a >= 4'hB);
  endfunction : is_nv

  // combined protection: pin pulled low, or the stored protect bit
  function automatic logic wp_active(input logic pin_n, input logic nv_bit);
    wp_active = !pin_n || nv_bit;
  endfunction : wp_active

  // ==========================================================
  // write-protect pin crosses from outside; two flops first
  pst_sync #(.W(1)) u_wp_sync (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_async   (i_wp_pin_n),
    .i_rst_val (1'b1),
    .o_sync    (wp_pin_n_s)
  );

  // ==========================================================
  // terminal control registers, lock masked per nibble
  assign is_write = i_req.valid && (i_req.cmd == PST_CMD_WRITE);
  assign tc0_wr   = is_write && allowed && (i_req.addr == ADR_TCTL0);
  assign tc1_wr   = is_write && allowed && (i_req.addr == ADR_TCTL1);

  pst_tctl_reg u_tc0 (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_wr     (tc0_wr),
    .i_wdata  (i_req.wdata),
    .i_lock   (st_r.lock[1:0]),
    .i_apply  (i_cmd_done),
    .o_value  (tc0_val),
    .o_switch (tc0_sw)
  );

  pst_tctl_reg u_tc1 (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_wr     (tc1_wr),
    .i_wdata  (i_req.wdata),
    .i_lock   (st_r.lock[3:2]),
    .i_apply  (i_cmd_done),
    .o_value  (tc1_val),
    .o_switch (tc1_sw)
  );

  // ==========================================================
  // command legality: busy window, disallowed ops, error latch
  always_comb begin
    allowed = !st_r.error;
    if (st_r.nvwa && !(i_req.addr == ADR_VWIP0 || i_req.addr == ADR_VWIP1 ||
        i_req.addr == ADR_TCTL0 || i_req.addr == ADR_STATUS)) begin
      allowed = 1'b0;
    end
    if (i_req.addr == ADR_STATUS && i_req.cmd != PST_CMD_READ) begin
      allowed = 1'b0;
    end
    if ((i_req.cmd == PST_CMD_INCR || i_req.cmd == PST_CMD_DECR) &&
        !is_vwiper(i_req.addr)) begin
      allowed = 1'b0;
    end
  end

  // ==========================================================
  // next-state: status mirrors, wiper updates, read data
  always_comb begin
    logic [2:0] net;
    logic       locked;
    logic [8:0] rd;
    net    = net_of(i_req.addr);
    locked = (net < 3'h4) && st_r.lock[net[1:0]];
    rd     = '0;
    st_nxt = st_r;
    st_nxt.lock   = i_nv_lock;
    st_nxt.wp_int = i_nv_wp;
    st_nxt.nvwa   = i_nv_write_active;
    st_nxt.rsp    = '0;
    st_nxt.nvw_req = 1'b0;
    if (i_err_clear) begin
      st_nxt.error = 1'b0;
    end
    if (i_req.valid) begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.done  = 1'b1;
      if (!allowed) begin
        st_nxt.rsp.error = 1'b1;
        st_nxt.error     = 1'b1;
      end else begin
        unique case (i_req.cmd)
          PST_CMD_READ: begin
            unique case (i_req.addr)
              ADR_STATUS: begin
                rd[ST_RSV8_BIT]  = 1'b1;
                rd[ST_RSV7_BIT]  = 1'b1;
                rd[ST_RSV1_BIT]  = 1'b1;
                rd[ST_LOCK3_BIT] = st_r.lock[3];
                rd[ST_LOCK2_BIT] = st_r.lock[2];
                rd[ST_LOCK1_BIT] = st_r.lock[1];
                rd[ST_LOCK0_BIT] = st_r.lock[0];
                rd[ST_NVWA_BIT]  = st_r.nvwa;
                rd[ST_WP_BIT]    = wp_active(wp_pin_n_s, st_r.wp_int);
              end
              ADR_TCTL0: rd = tc0_val;
              ADR_TCTL1: rd = tc1_val;
              ADR_VWIP0: rd = st_r.wiper[0];
              ADR_VWIP1: rd = st_r.wiper[1];
              ADR_VWIP2: rd = st_r.wiper[2];
              ADR_VWIP3: rd = st_r.wiper[3];
              default:   rd = '0;
            endcase
            st_nxt.rsp.rdata = rd;
          end
          PST_CMD_WRITE: begin
            if (is_vwiper(i_req.addr) && !locked) begin
              st_nxt.wiper[net[1:0]] = i_req.wdata;
            end else if (is_nv(i_req.addr)) begin
              if (!locked && !wp_active(wp_pin_n_s, st_r.wp_int)) begin
                st_nxt.nvw_req  = 1'b1;
                st_nxt.nvw_addr = i_req.addr;
                st_nxt.nvw_data = i_req.wdata;
              end
            end
          end
          PST_CMD_INCR: begin
            if (!locked && st_r.wiper[net[1:0]] < WFULL) begin
              st_nxt.wiper[net[1:0]] = st_r.wiper[net[1:0]] + 9'h001;
            end
          end
          PST_CMD_DECR: begin
            if (!locked && st_r.wiper[net[1:0]] != '0 &&
                st_r.wiper[net[1:0]] <= WFULL) begin
              st_nxt.wiper[net[1:0]] = st_r.wiper[net[1:0]] - 9'h001;
            end
          end
          default: ;
        endcase
      end
    end
    // switches follow only applied terminal values; wipers untouched
    for (int n = 0; n < 2; n++) begin
      st_nxt.term[n]   = pst_term_s'(tc0_sw[n*4 +: 4]);
      st_nxt.term[n+2] = pst_term_s'(tc1_sw[n*4 +: 4]);
    end
  end

  // ==========================================================
  // state register; locks reload from nv inputs the cycle after reset
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_r       <= '0;
      st_r.wiper <= {4{WIPER_RESET}};
      st_r.term  <= {4{4'hF}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rsp           = st_r.rsp;
  assign o_nv_write_req  = st_r.nvw_req;
  assign o_nv_write_addr = st_r.nvw_addr;
  assign o_nv_write_data = st_r.nvw_data;
  assign o_term          = st_r.term;
  assign o_wiper         = st_r.wiper;
endmodule : pst_regs

// file: verification/pst_regs_props.sv
/* pst_regs_props: port assertions for the potentiometer register bank.
   Assumes: bound to pst_regs; one clock, async active-high reset. */
`timescale 1ns/1ps
module pst_regs_props (
  input wire logic                     i_mclk,
  input wire logic                     i_rst,
  input wire pst_pkg::pst_req_s        i_req,
  input wire logic                     i_cmd_done,
  input wire logic                     i_nv_write_active,
  input wire logic [3:0]               i_nv_lock,
  input wire pst_pkg::pst_rsp_s        o_rsp,
  input wire pst_pkg::pst_term_s [3:0] o_term
);
  import pst_pkg::*;
  // ==========================================================
  // request decodes
  logic rd_st, rd_tc, wr_st, step_tc;
  assign rd_st = i_req.valid && i_req.cmd == PST_CMD_READ && i_req.addr == ADR_STATUS;
  assign rd_tc = i_req.valid && i_req.cmd == PST_CMD_READ &&
                 i_req.addr inside {ADR_TCTL0, ADR_TCTL1};
  assign wr_st = i_req.valid && i_req.cmd != PST_CMD_READ && i_req.addr == ADR_STATUS;
  assign step_tc = i_req.valid && i_req.cmd inside {PST_CMD_INCR, PST_CMD_DECR}
                   && i_req.addr inside {ADR_TCTL0, ADR_TCTL1};
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // assertions; refused reads may carry any data, so error excuses them
  a_st_reserved_ones: assert property (rd_st |=> o_rsp.error ||
    (o_rsp.rdata[8] && o_rsp.rdata[7] && o_rsp.rdata[1]))
    else $error("status reserved bits not one");
  a_tc_reserved_one: assert property (rd_tc |=> o_rsp.error || o_rsp.rdata[8])
    else $error("terminal reserved bit not one");
  a_st_lock_mirror: assert property (rd_st && $stable(i_nv_lock) |=> o_rsp.error
    || {o_rsp.rdata[6], o_rsp.rdata[5], o_rsp.rdata[3], o_rsp.rdata[2]} == $past(i_nv_lock))
    else $error("status lock bits differ from stored locks");
  a_st_busy_flag: assert property (rd_st && $stable(i_nv_write_active)
    |=> o_rsp.error || o_rsp.rdata[4] == $past(i_nv_write_active))
    else $error("status busy bit wrong");
  a_st_write_err: assert property (wr_st |=> o_rsp.valid && o_rsp.error)
    else $error("status write not refused");
  a_tc_step_err: assert property (step_tc |=> o_rsp.valid && o_rsp.error)
    else $error("step on terminal register not refused");
  a_busy_refuse: assert property (i_req.valid && i_nv_write_active
    && $past(i_nv_write_active) && !(i_req.addr inside {4'h0, 4'h1, 4'h4, 4'h5})
    |=> o_rsp.error)
    else $error("request during write cycle not refused");
  // live bits load on the completion edge, switch outputs one edge later
  a_term_deferred: assert property ($changed(o_term) |-> $past(i_cmd_done, 2))
    else $error("switches moved without command completion");
  cover property (rd_st);
  cover property (i_cmd_done ##2 $changed(o_term));
  cover property (o_rsp.valid && o_rsp.error);
endmodule : pst_regs_props
bind pst_regs pst_regs_props u_props (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req),
  .i_cmd_done(i_cmd_done), .i_nv_write_active(i_nv_write_active), .i_nv_lock(i_nv_lock),
  .o_rsp(o_rsp), .o_term(o_term));

// file: verification/pst_host.sv
/* pst_host: serial host model issuing decoded register commands.
   Assumes: answer one edge after the request; completion follows. */
`timescale 1ns/1ps
module pst_host (
  input  wire logic              i_mclk,
  input  wire pst_pkg::pst_rsp_s i_rsp,
  output pst_pkg::pst_req_s      o_req,
  output logic                   o_cmd_done
);
  import pst_pkg::*;
  // idle bus
  initial begin
    o_req = '0;
    o_cmd_done = 1'b0;
  end
  // ==========================================================
  // one command; idle address and data show the inverse so stale data never matches
  task automatic xfer(input pst_cmd_e c, input logic [3:0] a, input logic [8:0] d,
                      input int gap, output logic [8:0] q, output logic e);
    @(posedge i_mclk);
    #1 o_req = '{valid: 1'b1, cmd: c, addr: a, wdata: d};
    @(posedge i_mclk);
    #1 o_req = '{valid: 1'b0, cmd: c, addr: ~a, wdata: ~d};
    q = i_rsp.rdata;
    e = i_rsp.error | ~i_rsp.valid;
    repeat (gap) @(posedge i_mclk);
    #1 o_cmd_done = 1'b1;
    @(posedge i_mclk);
    #1 o_cmd_done = 1'b0;
  endtask : xfer
endmodule : pst_host

// file: verification/tb_top.sv
/* tb_top: self-checking bench for pst_regs with the host model.
   Assumes: 10 MHz clock; inputs change 1 ns after the rising edge. */
`timescale 1ns/1ps
module tb_top;
  import pst_pkg::*;
  logic i_mclk, i_rst, i_err_clear, i_wp_pin_n, i_nv_wp, i_nv_write_active, cmd_done;
  logic nv_req, nv_seen, nv_clr, e;
  logic [3:0] i_nv_lock, nv_addr;
  logic [8:0] nv_data, q;
  pst_req_s req;
  pst_rsp_s rsp;
  pst_term_s [3:0] term;
  logic [3:0][8:0] wiper;
  int failures, comparisons;
  pst_host u_host (.i_mclk(i_mclk), .i_rsp(rsp), .o_req(req), .o_cmd_done(cmd_done));
  pst_regs #(.WIPER_FULL(256)) dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(req),
    .i_cmd_done(cmd_done), .i_err_clear(i_err_clear), .i_wp_pin_n(i_wp_pin_n),
    .i_nv_wp(i_nv_wp), .i_nv_lock(i_nv_lock), .i_nv_write_active(i_nv_write_active),
    .o_rsp(rsp), .o_nv_write_req(nv_req), .o_nv_write_addr(nv_addr),
    .o_nv_write_data(nv_data), .o_term(term), .o_wiper(wiper));
  // clock
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  // latch any nonvolatile write request; nv_clr empties the latch
  always @(posedge i_mclk) nv_seen <= (nv_seen && !nv_clr) || nv_req;
  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cmd(input pst_cmd_e c, input logic [3:0] a, input logic [8:0] d, input logic ee);
    u_host.xfer(c, a, d, 0, q, e);
    chk("error flag", 16'(ee), 16'(e));
  endtask : cmd
  task automatic rd(input logic [3:0] a, input logic [8:0] exp);
    cmd(PST_CMD_READ, a, 9'h000, 1'b0);
    chk("read data", 16'(exp), 16'(q));
  endtask : rd
  task automatic clr;
    @(posedge i_mclk);
    #1 i_err_clear = 1'b1;
    @(posedge i_mclk);
    #1 i_err_clear = 1'b0;
  endtask : clr
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : idle
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(ADR_TCTL0, 9'h1FF);
    rd(ADR_TCTL1, 9'h1FF);
    chk("switches", 16'hFFFF, term);
    rd(ADR_STATUS, 9'h182);
  endtask : t_reset
  task automatic t_apply;
    fork
      u_host.xfer(PST_CMD_WRITE, ADR_TCTL0, 9'h0F0, 3, q, e);
      begin
        idle(3);
        chk("switches early", 16'hFFFF, term);
      end
    join
    chk("error flag", 16'h0000, 16'(e));
    // switch outputs follow one edge after the completion edge
    idle(1);
    chk("switches net0", 16'hFFF0, term);
    cmd(PST_CMD_WRITE, ADR_TCTL1, 9'h05A, 1'b0);
    idle(1);
    chk("switches", 16'h5AF0, term);
    rd(ADR_TCTL0, 9'h1F0);
    chk("wiper0", 16'(WIPER_RESET), 16'(wiper[0]));
  endtask : t_apply
  task automatic t_lock;
    i_nv_lock = 4'b0001;
    idle(2);
    rd(ADR_STATUS, 9'h186);
    cmd(PST_CMD_WRITE, ADR_TCTL0, 9'h00F, 1'b0);
    rd(ADR_TCTL0, 9'h100);
    cmd(PST_CMD_WRITE, ADR_VWIP0, 9'h055, 1'b0);
    chk("locked wiper0", 16'(WIPER_RESET), 16'(wiper[0]));
    cmd(PST_CMD_WRITE, ADR_VWIP1, 9'h055, 1'b0);
    chk("wiper1", 16'h0055, 16'(wiper[1]));
    i_nv_lock = 4'b0000;
  endtask : t_lock
  task automatic t_protect;
    i_wp_pin_n = 1'b0;
    idle(4);
    nv_clr = 1'b0;
    rd(ADR_STATUS, 9'h183);
    cmd(PST_CMD_WRITE, ADR_NVWIP0, 9'h011, 1'b0);
    cmd(PST_CMD_INCR, ADR_VWIP1, 9'h000, 1'b0);
    chk("nv write blocked", 16'h0000, 16'(nv_seen));
    chk("wiper1 step", 16'h0056, 16'(wiper[1]));
    cmd(PST_CMD_WRITE, ADR_TCTL0, 9'h1FF, 1'b0);
    rd(ADR_TCTL0, 9'h1FF);
    cmd(PST_CMD_WRITE, ADR_VWIP2, 9'h0FF, 1'b0);
    cmd(PST_CMD_INCR, ADR_VWIP2, 9'h000, 1'b0);
    cmd(PST_CMD_INCR, ADR_VWIP2, 9'h000, 1'b0);
    cmd(PST_CMD_DECR, ADR_VWIP3, 9'h000, 1'b0);
    chk("wiper2 clamp", 16'h0100, 16'(wiper[2]));
    chk("wiper3 down", 16'h007F, 16'(wiper[3]));
    i_wp_pin_n = 1'b1;
    i_nv_wp = 1'b1;
    idle(4);
    rd(ADR_STATUS, 9'h183);
    i_nv_wp = 1'b0;
    idle(4);
    cmd(PST_CMD_WRITE, ADR_NVWIP0, 9'h011, 1'b0);
    idle(2);
    chk("nv write issued", 16'h0001, 16'(nv_seen));
    chk("nv write addr", 16'(ADR_NVWIP0), 16'(nv_addr));
    chk("nv write data", 16'h0011, 16'(nv_data));
  endtask : t_protect
  task automatic t_error;
    i_nv_write_active = 1'b1;
    idle(2);
    rd(ADR_STATUS, 9'h192);
    cmd(PST_CMD_WRITE, ADR_NVWIP1, 9'h001, 1'b1);
    clr();
    cmd(PST_CMD_WRITE, ADR_VWIP0, 9'h001, 1'b0);
    i_nv_write_active = 1'b0;
    cmd(PST_CMD_WRITE, ADR_STATUS, 9'h000, 1'b1);
    cmd(PST_CMD_READ, ADR_STATUS, 9'h000, 1'b1);
    clr();
    rd(ADR_STATUS, 9'h182);
    cmd(PST_CMD_INCR, ADR_TCTL0, 9'h000, 1'b1);
    clr();
    cmd(PST_CMD_DECR, ADR_NVWIP0, 9'h000, 1'b1);
    clr();
  endtask : t_error
  // mid-run reset: terminals back to all connected, locks reloaded
  task automatic t_rst_again;
    i_nv_lock = 4'b1000;
    i_rst = 1'b1;
    idle(2);
    chk("switches", 16'hFFFF, term);
    i_rst = 1'b0;
    idle(2);
    rd(ADR_TCTL1, 9'h1FF);
    rd(ADR_VWIP0, WIPER_RESET);
    rd(ADR_STATUS, 9'h1C2);
    i_nv_lock = 4'h0;
  endtask : t_rst_again
  // ==========================================================
  // verdict and run control
  task automatic print_verdict;
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // watchdog well past the expected run of about 140 cycles
  initial begin
    repeat (3000) @(posedge i_mclk);
    failures++;
    print_verdict();
  end
  // main sequence
  initial begin
    {i_rst, i_err_clear, i_nv_wp, i_nv_write_active, nv_clr} = 5'b10001;
    i_wp_pin_n = 1'b1;
    i_nv_lock = 4'h0;
    repeat (6) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    idle(2);
    t_reset();
    t_apply();
    t_lock();
    t_protect();
    t_error();
    t_rst_again();
    print_verdict();
  end
endmodule : tb_top
